// file: pabm_pkg.sv
// Shared constants for the port A/B alternate-function pin mux
package pabm_pkg;

  // --------------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------------
  localparam int PORT_W = 8;

  // --------------------------------------------------------------------
  // Port B pin positions
  // --------------------------------------------------------------------
  localparam int SCK_BIT = 7;
  localparam int MISO_BIT = 6;
  localparam int MOSI_BIT = 5;
  localparam int SS_BIT = 4;
  localparam int CMP_NEG_BIT = 3;
  localparam int CMP_POS_BIT = 2;
  localparam int T1_BIT = 1;
  localparam int T0_BIT = 0;

  // --------------------------------------------------------------------
  // Reset values and all-ones/all-zero fill constants
  // --------------------------------------------------------------------
  localparam logic [PORT_W-1:0] PULLUP_RST = 8'h00;
  localparam logic [PORT_W-1:0] DRIVE_EN_RST = 8'h00;
  localparam logic [PORT_W-1:0] DRIVE_VAL_RST = 8'h00;
  localparam logic [PORT_W-1:0] INPUT_EN_RST = 8'hff;
  localparam logic [PORT_W-1:0] RDATA_RST = 8'h00;
  localparam logic [PORT_W-1:0] ALL_ONES = 8'hff;
  localparam logic [PORT_W-1:0] ALL_ZERO = 8'h00;
  localparam logic BIT_RST = 1'b0;
  localparam logic SS_IN_RST = 1'b1;

endpackage

// file: pabm_port_mux.sv
// Pin override mux for ports A and B with external memory, SPI and timer functions
`timescale 1ns/10ps
// Operation
// - Global pull-up off kills every non-overridden pull-up, even direction 0 output 1.
// - With external memory on, port A pin n carries address/data bit n.
// - External memory on: pull-up, direction, value overrides set; input override clear.
// - Port A drives address in address phase, write data during write strobe.
// - Port A idle: pull-up equals output bit; pin input is read data.
// - Port B bits 7..4 SCK MISO MOSI SS; bit 3 negative, 2 positive comparator.
// - Port B bit 1 timer1 count in; bit 0 timer0 count in and compare out.
// - SPI slave forces SCK input; master lets direction bit decide.
// - SPI master forces MISO input; slave lets direction bit decide.
// - SPI slave forces MOSI input; master lets direction bit decide.
// - SPI slave forces slave select input; master lets direction bit decide.
// - SPI slave is active only while slave select pin is low.
// - SPI-forced inputs keep pull-up controlled by their output bit.
// - Pull-up follows override value if enabled, else direction 0 output 1 no disable.
// - Driver follows direction override value if enabled, else direction bit.
// - Driven value is value override if enabled, else the output bit.
// - Input enable follows override value if enabled, else not asleep.
module pabm_port_mux
  import pabm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic global_pullup_off_i,
  input wire logic sleep_active_i,
  input wire logic [PORT_W-1:0] porta_direction_i,
  input wire logic [PORT_W-1:0] porta_output_i,
  input wire logic [PORT_W-1:0] porta_pin_i,
  input wire logic ext_mem_enable_i,
  input wire logic address_phase_active_i,
  input wire logic write_strobe_i,
  input wire logic [PORT_W-1:0] ext_mem_addr_i,
  input wire logic [PORT_W-1:0] ext_mem_wdata_i,
  output logic [PORT_W-1:0] ext_mem_rdata_o,
  output logic [PORT_W-1:0] porta_pin_o,
  output logic [PORT_W-1:0] porta_pin_oe_o,
  output logic [PORT_W-1:0] porta_pullup_o,
  output logic [PORT_W-1:0] porta_input_en_o,
  input wire logic [PORT_W-1:0] portb_direction_i,
  input wire logic [PORT_W-1:0] portb_output_i,
  input wire logic [PORT_W-1:0] portb_pin_i,
  input wire logic spi_enable_i,
  input wire logic spi_master_i,
  input wire logic spi_sck_out_i,
  input wire logic spi_slave_out_i,
  input wire logic spi_master_out_i,
  input wire logic timer0_compare_en_i,
  input wire logic timer0_compare_output_i,
  output logic [PORT_W-1:0] portb_pin_o,
  output logic [PORT_W-1:0] portb_pin_oe_o,
  output logic [PORT_W-1:0] portb_pullup_o,
  output logic [PORT_W-1:0] portb_input_en_o,
  output logic spi_sck_in_o,
  output logic spi_master_in_o,
  output logic spi_slave_in_o,
  output logic spi_slave_select_o,
  output logic spi_slave_active_o,
  output logic timer1_count_input_o,
  output logic timer0_count_input_o
);

  // --------------------------------------------------------------------
  // Generic override resolution
  // --------------------------------------------------------------------
  function automatic logic [PORT_W-1:0] f_pullup(
    input logic [PORT_W-1:0] dir,
    input logic [PORT_W-1:0] outb,
    input logic global_pullup_off,
    input logic [PORT_W-1:0] oe,
    input logic [PORT_W-1:0] ov
  );
    f_pullup = (oe & ov) | (~oe & ~dir & outb & {PORT_W{~global_pullup_off}});
  endfunction

  function automatic logic [PORT_W-1:0] f_select(
    input logic [PORT_W-1:0] base,
    input logic [PORT_W-1:0] oe,
    input logic [PORT_W-1:0] ov
  );
    f_select = (oe & ov) | (~oe & base);
  endfunction

  // --------------------------------------------------------------------
  // Port A overrides
  // --------------------------------------------------------------------
  logic a_bus_drive;
  logic [PORT_W-1:0] a_en;
  logic [PORT_W-1:0] a_pullup_override_val;
  logic [PORT_W-1:0] a_direction_override_val;
  logic [PORT_W-1:0] a_value_override_val;
  logic [PORT_W-1:0] a_pu_d;
  logic [PORT_W-1:0] a_oe_d;
  logic [PORT_W-1:0] a_val_d;
  logic [PORT_W-1:0] a_ie_d;

  always_comb begin
    a_bus_drive = address_phase_active_i | write_strobe_i;
    a_en = {PORT_W{ext_mem_enable_i}};
    a_pullup_override_val = {PORT_W{~a_bus_drive}} & porta_output_i;
    a_direction_override_val = {PORT_W{a_bus_drive}};
    if (address_phase_active_i) begin
      a_value_override_val = ext_mem_addr_i;
    end else if (write_strobe_i) begin
      a_value_override_val = ext_mem_wdata_i;
    end else begin
      a_value_override_val = ALL_ZERO;
    end
    a_pu_d = f_pullup(porta_direction_i, porta_output_i, global_pullup_off_i, a_en, a_pullup_override_val);
    a_oe_d = f_select(porta_direction_i, a_en, a_direction_override_val);
    a_val_d = f_select(porta_output_i, a_en, a_value_override_val);
    a_ie_d = f_select({PORT_W{~sleep_active_i}}, ALL_ZERO, ALL_ZERO);
  end

  // --------------------------------------------------------------------
  // Port B overrides
  // --------------------------------------------------------------------
  logic spi_slave;
  logic spi_mstr;
  logic [PORT_W-1:0] b_pullup_override_en;
  logic [PORT_W-1:0] b_direction_override_en;
  logic [PORT_W-1:0] b_value_override_en;
  logic [PORT_W-1:0] b_value_override_val;
  logic [PORT_W-1:0] b_pullup_override_val;
  logic [PORT_W-1:0] b_pu_d;
  logic [PORT_W-1:0] b_oe_d;
  logic [PORT_W-1:0] b_val_d;
  logic [PORT_W-1:0] b_ie_d;

  always_comb begin
    spi_slave = spi_enable_i & ~spi_master_i;
    spi_mstr = spi_enable_i & spi_master_i;
    b_pullup_override_en = ALL_ZERO;
    b_direction_override_en = ALL_ZERO;
    b_value_override_en = ALL_ZERO;
    b_value_override_val = ALL_ZERO;
    b_pullup_override_en[SCK_BIT] = spi_slave;
    b_direction_override_en[SCK_BIT] = spi_slave;
    b_pullup_override_en[MISO_BIT] = spi_mstr;
    b_direction_override_en[MISO_BIT] = spi_mstr;
    b_pullup_override_en[MOSI_BIT] = spi_slave;
    b_direction_override_en[MOSI_BIT] = spi_slave;
    b_pullup_override_en[SS_BIT] = spi_slave;
    b_direction_override_en[SS_BIT] = spi_slave;
    b_value_override_en[SCK_BIT] = spi_mstr;
    b_value_override_val[SCK_BIT] = spi_sck_out_i;
    b_value_override_en[MISO_BIT] = spi_slave;
    b_value_override_val[MISO_BIT] = spi_slave_out_i;
    b_value_override_en[MOSI_BIT] = spi_mstr;
    b_value_override_val[MOSI_BIT] = spi_master_out_i;
    b_value_override_en[T0_BIT] = timer0_compare_en_i;
    b_value_override_val[T0_BIT] = timer0_compare_output_i;
    b_pullup_override_val = portb_output_i & {PORT_W{~global_pullup_off_i}};
    b_pu_d = f_pullup(portb_direction_i, portb_output_i, global_pullup_off_i, b_pullup_override_en, b_pullup_override_val);
    b_oe_d = f_select(portb_direction_i, b_direction_override_en, ALL_ZERO);
    b_val_d = f_select(portb_output_i, b_value_override_en, b_value_override_val);
    b_ie_d = f_select({PORT_W{~sleep_active_i}}, ALL_ZERO, ALL_ZERO);
  end

  // --------------------------------------------------------------------
  // Pad control registers
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      porta_pullup_o <= PULLUP_RST;
      porta_pin_oe_o <= DRIVE_EN_RST;
      porta_pin_o <= DRIVE_VAL_RST;
      porta_input_en_o <= INPUT_EN_RST;
    end else begin
      porta_pullup_o <= a_pu_d;
      porta_pin_oe_o <= a_oe_d;
      porta_pin_o <= a_val_d;
      porta_input_en_o <= a_ie_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      portb_pullup_o <= PULLUP_RST;
      portb_pin_oe_o <= DRIVE_EN_RST;
      portb_pin_o <= DRIVE_VAL_RST;
      portb_input_en_o <= INPUT_EN_RST;
    end else begin
      portb_pullup_o <= b_pu_d;
      portb_pin_oe_o <= b_oe_d;
      portb_pin_o <= b_val_d;
      portb_input_en_o <= b_ie_d;
    end
  end

  // --------------------------------------------------------------------
  // Alternate function inputs
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_mem_rdata_o <= RDATA_RST;
    end else begin
      ext_mem_rdata_o <= porta_pin_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_sck_in_o <= BIT_RST;
      spi_master_in_o <= BIT_RST;
      spi_slave_in_o <= BIT_RST;
      spi_slave_select_o <= SS_IN_RST;
      spi_slave_active_o <= BIT_RST;
      timer1_count_input_o <= BIT_RST;
      timer0_count_input_o <= BIT_RST;
    end else begin
      spi_sck_in_o <= portb_pin_i[SCK_BIT];
      spi_master_in_o <= portb_pin_i[MISO_BIT];
      spi_slave_in_o <= portb_pin_i[MOSI_BIT];
      spi_slave_select_o <= portb_pin_i[SS_BIT];
      spi_slave_active_o <= spi_slave & ~portb_pin_i[SS_BIT];
      timer1_count_input_o <= portb_pin_i[T1_BIT];
      timer0_count_input_o <= portb_pin_i[T0_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence s_spi_slave;
    spi_enable_i && !spi_master_i;
  endsequence

  sequence s_spi_master;
    spi_enable_i && spi_master_i;
  endsequence

  sequence s_gpio_b;
    !spi_enable_i && !timer0_compare_en_i;
  endsequence

  property p_pud_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      global_pullup_off_i && !ext_mem_enable_i ##0 s_gpio_b |=>
        porta_pullup_o == ALL_ZERO && portb_pullup_o == ALL_ZERO;
  endproperty
  a_pud_off: assert property (p_pud_off) else $error("pull-up on while disabled");

  property p_addr_drive;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ext_mem_enable_i && address_phase_active_i |=>
        porta_pin_oe_o == ALL_ONES && porta_pin_o == $past(ext_mem_addr_i);
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("address not on port A");

  property p_ext_input_en;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ext_mem_enable_i |=> porta_input_en_o == {PORT_W{!$past(sleep_active_i)}};
  endproperty
  a_ext_input_en: assert property (p_ext_input_en) else $error("input enable overridden");

  property p_write_drive;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ext_mem_enable_i && write_strobe_i && !address_phase_active_i |=>
        porta_pin_oe_o == ALL_ONES && porta_pin_o == $past(ext_mem_wdata_i);
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("write data not on port A");

  property p_idle_pullup;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ext_mem_enable_i && !address_phase_active_i && !write_strobe_i |=>
        porta_pullup_o == $past(porta_output_i) && porta_pin_oe_o == ALL_ZERO;
  endproperty
  a_idle_pullup: assert property (p_idle_pullup) else $error("idle port A pull-up wrong");

  property p_rdata;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      1'b1 |=> ext_mem_rdata_o == $past(porta_pin_i);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not from pins");

  property p_slave_inputs;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_spi_slave |=> !portb_pin_oe_o[SCK_BIT] && !portb_pin_oe_o[MOSI_BIT]
        && !portb_pin_oe_o[SS_BIT]
        && portb_pin_oe_o[MISO_BIT] == $past(portb_direction_i[MISO_BIT]);
  endproperty
  a_slave_inputs: assert property (p_slave_inputs) else $error("slave pin direction wrong");

  property p_master_inputs;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_spi_master |=> !portb_pin_oe_o[MISO_BIT]
        && portb_pin_oe_o[SCK_BIT] == $past(portb_direction_i[SCK_BIT]);
  endproperty
  a_master_inputs: assert property (p_master_inputs) else $error("master pin direction wrong");

  property p_slave_active;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_spi_slave ##0 portb_pin_i[SS_BIT] |=> !spi_slave_active_o;
  endproperty
  a_slave_active: assert property (p_slave_active) else $error("slave active with select high");

  property p_forced_pullup;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_spi_slave ##0 !global_pullup_off_i |=>
        portb_pullup_o[SCK_BIT] == $past(portb_output_i[SCK_BIT]);
  endproperty
  a_forced_pullup: assert property (p_forced_pullup) else $error("forced input pull-up wrong");

  property p_gpio_b;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_gpio_b |=> portb_pin_oe_o == $past(portb_direction_i)
        && portb_pin_o == $past(portb_output_i);
  endproperty
  a_gpio_b: assert property (p_gpio_b) else $error("plain port B drive wrong");

  property p_oc0;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      timer0_compare_en_i |=> portb_pin_o[T0_BIT] == $past(timer0_compare_output_i);
  endproperty
  a_oc0: assert property (p_oc0) else $error("compare output not on bit 0");

endmodule

// file: pabm_alt_model.sv
// Far-side model: external memory bus phases, SPI and timer0 drive values
`timescale 1ns/10ps
module pabm_alt_model
  import pabm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] rnd_i,
  output logic address_phase_active_o,
  output logic write_strobe_o,
  output logic [PORT_W-1:0] ext_mem_addr_o,
  output logic [PORT_W-1:0] ext_mem_wdata_o,
  output logic spi_sck_out_o,
  output logic spi_slave_out_o,
  output logic spi_master_out_o,
  output logic timer0_compare_output_o
);
  // ------------------------------------------------------------------
  // Bus phase sequencer: idle, address, data
  // ------------------------------------------------------------------
  logic [1:0] phase_q;
  logic wr_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= 2'h0;
      wr_q <= 1'b0;
    end else begin
      phase_q <= (phase_q == 2'h0) ? {1'b0, rnd_i[0]} : ((phase_q == 2'h1) ? 2'h2 : 2'h0);
      wr_q <= (phase_q == 2'h1) ? rnd_i[1] : wr_q;
    end
  end
  assign address_phase_active_o = (phase_q == 2'h1);
  assign write_strobe_o = (phase_q == 2'h2) & wr_q;
  // Address held through address phase, data through data phase
  always_ff @(posedge ref_clk_i) begin
    if (phase_q != 2'h1) begin
      ext_mem_addr_o <= rnd_i[15:8];
    end
    if (phase_q != 2'h2) begin
      ext_mem_wdata_o <= rnd_i[23:16];
    end
  end
  // Serial and compare drive values change freely
  always_ff @(posedge ref_clk_i) begin
    spi_sck_out_o <= rnd_i[20];
    spi_slave_out_o <= rnd_i[21];
    spi_master_out_o <= rnd_i[22];
    timer0_compare_output_o <= rnd_i[25];
  end
endmodule

// file: tb_pabm_port_mux.sv
// Self-checking bench for the port A/B pin mux
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    tests_run++; \
    if ((a) !== (b)) begin \
      mismatches++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module tb_pabm_port_mux;
  import pabm_pkg::*;
  typedef struct {
    logic [PORT_W-1:0] rd, ap, ao, au, ai, bp, bo, bu, bi;
    logic [6:0] s;
  } pabm_exp_t;
  logic clk, rst_n, run, global_pullup_off, slp, em, spe, mst, t0e;
  logic [PORT_W-1:0] ad, ao, ap, bd, bo, bp;
  logic [31:0] rnd;
  wire logic [PORT_W-1:0] rd, pa_o, pa_oe, pa_pu, pa_ie, pb_o, pb_oe, pb_pu, pb_ie;
  wire logic sck, miso, mosi, ssel, sact, t1, t0;
  wire logic ada, wr, sck_o, so, mo, oc;
  wire logic [PORT_W-1:0] addr, wd;
  int mismatches = 0;
  int tests_run = 0;
  pabm_exp_t q[$];
  pabm_exp_t ce;
  always #2.5 clk = ~clk;
  pabm_port_mux u_pabm_port_mux (.ref_clk_i(clk), .rst_n_i(rst_n),
    .global_pullup_off_i(global_pullup_off), .sleep_active_i(slp), .porta_direction_i(ad),
    .porta_output_i(ao), .porta_pin_i(ap), .ext_mem_enable_i(em),
    .address_phase_active_i(ada), .write_strobe_i(wr), .ext_mem_addr_i(addr),
    .ext_mem_wdata_i(wd), .ext_mem_rdata_o(rd), .porta_pin_o(pa_o),
    .porta_pin_oe_o(pa_oe), .porta_pullup_o(pa_pu), .porta_input_en_o(pa_ie),
    .portb_direction_i(bd), .portb_output_i(bo), .portb_pin_i(bp),
    .spi_enable_i(spe), .spi_master_i(mst), .spi_sck_out_i(sck_o),
    .spi_slave_out_i(so), .spi_master_out_i(mo), .timer0_compare_en_i(t0e),
    .timer0_compare_output_i(oc), .portb_pin_o(pb_o), .portb_pin_oe_o(pb_oe),
    .portb_pullup_o(pb_pu), .portb_input_en_o(pb_ie), .spi_sck_in_o(sck),
    .spi_master_in_o(miso), .spi_slave_in_o(mosi), .spi_slave_select_o(ssel),
    .spi_slave_active_o(sact), .timer1_count_input_o(t1), .timer0_count_input_o(t0));
  pabm_alt_model u_pabm_alt_model (.ref_clk_i(clk), .rst_n_i(rst_n), .rnd_i(rnd),
    .address_phase_active_o(ada), .write_strobe_o(wr), .ext_mem_addr_o(addr),
    .ext_mem_wdata_o(wd), .spi_sck_out_o(sck_o), .spi_slave_out_o(so),
    .spi_master_out_o(mo), .timer0_compare_output_o(oc));
  // ------------------------------------------------------------------
  // Expected pad controls
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic pabm_exp_t calc();
    pabm_exp_t e;
    logic [PORT_W-1:0] fm, vm, vv;
    e.rd = ap;
    e.ao = em ? {PORT_W{ada | wr}} : ad;
    e.ap = !em ? ao : (ada ? addr : wd);
    e.au = em ? ((ada | wr) ? ALL_ZERO : ao) : ~ad & ao & {PORT_W{~global_pullup_off}};
    e.ai = slp ? ALL_ZERO : ALL_ONES;
    fm = !spe ? ALL_ZERO : (mst ? 8'h40 : 8'hb0);
    vm = {!spe ? 3'h0 : (mst ? 3'h5 : 3'h2), 4'h0, t0e};
    vv = {sck_o, so, mo, 4'h0, oc};
    e.bo = bd & ~fm;
    e.bp = (vm & vv) | (~vm & bo);
    e.bu = (~bd | fm) & bo & {PORT_W{~global_pullup_off}};
    e.bi = e.ai;
    e.s = {bp[7], bp[6], bp[5], bp[4], spe & !mst & !bp[4], bp[1], bp[0]};
    return e;
  endfunction
  // ------------------------------------------------------------------
  // Driver and result watcher
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (run) begin
      q.push_back(calc());
      rnd <= xs(rnd);
      ad <= rnd[7:0];
      ao <= rnd[15:8];
      bd <= spe ? rnd[23:16] & 8'hf3 : rnd[23:16];
      bo <= spe ? rnd[31:24] & 8'hf3 : rnd[31:24];
      global_pullup_off <= rnd[2] & rnd[9];
      slp <= rnd[4] & rnd[11];
      t0e <= rnd[6];
      ap <= (pa_oe & pa_o) | (~pa_oe & ~rnd[31:24]);
      bp <= (pb_oe & pb_o) | (~pb_oe & (rnd[7:0] ^ rnd[23:16]));
    end
  end
  always @(negedge clk) begin
    if (q.size() > 0) begin
      ce = q.pop_front();
      `CHK(rd, ce.rd)
      `CHK(pa_oe, ce.ao)
      `CHK(pa_o & ce.ao, ce.ap & ce.ao)
      `CHK(pa_pu, ce.au)
      `CHK(pa_ie, ce.ai)
      `CHK(pb_oe, ce.bo)
      `CHK(pb_o & ce.bo, ce.bp & ce.bo)
      `CHK(pb_pu, ce.bu)
      `CHK(pb_ie, ce.bi)
      `CHK({sck, miso, mosi, ssel, sact, t1, t0}, ce.s)
    end
  end
  task automatic chk_rst();
    `CHK(pa_pu, PULLUP_RST)
    `CHK(pa_oe, DRIVE_EN_RST)
    `CHK(pb_pu, PULLUP_RST)
    `CHK(pb_oe, DRIVE_EN_RST)
    `CHK(pa_ie, INPUT_EN_RST)
    `CHK(sact, BIT_RST)
    $display("test reset done");
  endtask
  task automatic phase(input logic [2:0] m);
    em <= m[2];
    spe <= m[1];
    mst <= m[0];
    run <= 1'b1;
    repeat (40) @(posedge clk);
    $display("test mode %h done", m);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    {clk, rst_n, run, global_pullup_off, slp, em, spe, mst, t0e} = 9'h000;
    {ad, ao, ap, bd, bo, bp} = 48'h0;
    rnd = 32'h0000_1534;
    @(posedge clk);
    @(negedge clk);
    chk_rst();
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) phase(i[2:0]);
    run <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk_rst();
    @(posedge clk);
    rst_n <= 1'b1;
    phase(3'h4);
    run <= 1'b0;
    repeat (2) @(posedge clk);
    stop_test();
  end
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule
